// ===== core/pco_cfg.svh
// Purpose: Offsets, reset values, field positions of the PCM output block
// Assumes: 8-bit register port, byte offsets as printed
// Notes: Definitions only
`ifndef PCO_CFG_SVH
`define PCO_CFG_SVH
`define PCO_OFS_SETUP 8'h55
`define PCO_OFS_SWAP 8'h56
`define PCO_OFS_ODIV 8'h61
`define PCO_OFS_TRACK 8'h63
`define PCO_OFS_FRAC_L 8'h64
`define PCO_OFS_FRAC_H 8'h65
`define PCO_OFS_TALLY_L 8'h67
`define PCO_OFS_TALLY_M 8'h68
`define PCO_OFS_TALLY_H 8'h69
`define PCO_OFS_RATE 8'h6a
`define PCO_OFS_FWREV 8'h71
`define PCO_OFS_RUN 8'h72
`define PCO_RST_SETUP 7'h21
`define PCO_RST_SWAP 2'h0
`define PCO_RST_ODIV 5'h07
`define PCO_RST_FRAC_L 8'h46
`define PCO_RST_FRAC_H 8'h5b
`define PCO_MASK_SETUP 8'h7f
`define PCO_MASK_SWAP 8'h03
`define PCO_MASK_ODIV 8'h1f
`define PCO_SLOT16 6'h1f
`define PCO_SLOT32 6'h3f
`define PCO_FIFO_DEPTH 16
`endif

// ===== core/pco_pkg.sv
// Purpose: Types of the PCM output and clock configuration block
// Assumes: Used with pco_cfg.svh
// Notes: Field order of pco_setup_s matches register bits 6..0
package pco_pkg;
  typedef enum logic [1:0] {PCO_W16, PCO_W18, PCO_W20, PCO_W24} pco_width_e;
  typedef enum logic [1:0] {PCO_MAP_THRU, PCO_MAP_LEFT, PCO_MAP_RIGHT,
    PCO_MAP_SWAP} pco_map_e;
  typedef enum logic [1:0] {PCO_FS256, PCO_FS384, PCO_FS512,
    PCO_FS_RSV} pco_ratio_e;
  typedef struct packed {
    logic lsb_first_select;
    logic pad_side_select;
    logic frame_polarity_flip;
    logic serial_style_select;
    logic bitclock_edge_select;
    pco_width_e sample_width_select;
  } pco_setup_s;
  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } pco_frame_s;
  typedef struct packed {
    logic [15:0] fine_tune;
    logic [4:0] out_div;
    logic tracking;
    pco_ratio_e ratio;
  } pco_pll_s;
endpackage : pco_pkg

// ===== core/pco_top.sv
// Purpose: PCM serial output, its setup registers and PLL settings
// Assumes: clk_i 20 MHz; oversampling clock pin slower than clk_i/2
// Notes: Samples are 24-bit, MSB at bit 23, left channel first
`timescale 1ns/1ps
`default_nettype none
`include "pco_cfg.svh"

module pco_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rptr_reg];
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wptr_reg] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop)
      begin
        rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // pco_fifo

// Behaviour
// - lsb_first_select 1 shifts LSB first, 0 shifts MSB first.
// - In 18/20/24 bit modes pad_side_select 0 pads right, 1 left.
// - frame_polarity_flip 1: word select low left; 0: inverted; reset 0.
// - serial_style_select 0 I2S, 1 other; cleared by hard and soft reset.
// - bitclock_edge_select 1 launches on falling bit clock edge; default 0.
// - Width code 00 16/16 slots, 01 18, 10 20, 11 24 in 32 slots.
// - 32 bit clocks per word period in 16 bit mode, else 64.
// - Channel map: straight, left both, right both, exchanged; reset 0.
// - Oversampling path divides oscillator by pll_output_divider plus one.
// - Device rewrites pll_output_divider for the stream; host may write too.
// - Tracking mode 1 keeps the host-set oversampling frequency fixed.
// - Tracking mode 0 follows Fs at 512, 384 or 256; 256 default.
// - Default oversampling clock frequency is 12.288 MHz.
// - Fine-tune bytes form one 16-bit word; loaded at stream sync.
// - Oversampling clock is MCLK/(N+1)*(M+1+F/65536)/(X+1).
// - 24-bit read-only frame tally counts frames; cleared on any reset.
// - mean_stream_rate reports average bitrate halved, 1 kbit/s accuracy.
// - firmware_revision reports the embedded firmware version code.
// - Writing 1 to run leaves idle and starts decoding.
// - Operation mode sampled at run only; soft reset needed to change.
// - Bit clock is oversampling clock over twice one plus divider.
module pco_top #(
  parameter logic [7:0] FW_REVISION = 8'h5a, // Arbitrary value
  parameter int FIFO_DEPTH = `PCO_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic soft_reset_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Decode engine side
  input wire logic [4:0] core_div_i,
  input wire logic core_div_wr_i,
  input wire logic stream_sync_i,
  input wire logic frame_done_i,
  input wire logic [8:0] avg_rate_kbps_i,
  input wire logic [2:0] operation_select_i,
  output logic [2:0] op_mode_o,
  output logic running_o,
  // Sample stream
  input wire pco_pkg::pco_frame_s pcm_data_i,
  input wire logic pcm_valid_i,
  output logic pcm_ready_o,
  // PLL settings
  input wire pco_pkg::pco_ratio_e fs_ratio_i,
  output pco_pkg::pco_pll_s pll_o,
  // Serial output pins
  input wire logic ovs_clk_i,
  input wire logic [7:0] bit_clock_divider_i,
  output logic serial_bit_clock_o,
  output logic word_select_clock_o,
  output logic serial_data_o
);
  import pco_pkg::*;

  pco_setup_s setup_reg;
  pco_map_e swap_reg;
  logic [4:0] odiv_reg;
  logic track_reg;
  logic [7:0] frac_l_reg;
  logic [7:0] frac_h_reg;
  logic [15:0] frac_op_reg;
  logic [23:0] tally_reg;
  logic [7:0] rate_reg;
  logic run_reg;
  logic [2:0] op_mode_reg;
  logic sync_d_reg;
  logic [7:0] rdata_reg;
  logic host_wr_odiv;
  logic run_set;

  assign host_wr_odiv = reg_wr_i && (reg_addr_i == `PCO_OFS_ODIV);
  assign run_set = reg_wr_i && (reg_addr_i == `PCO_OFS_RUN) && reg_wdata_i[0];

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      setup_reg <= `PCO_RST_SETUP;
      swap_reg <= pco_map_e'(`PCO_RST_SWAP);
      track_reg <= 1'b0;
      frac_l_reg <= `PCO_RST_FRAC_L;
      frac_h_reg <= `PCO_RST_FRAC_H;
    end
    else if (soft_reset_i)
    begin
      setup_reg <= `PCO_RST_SETUP;
      swap_reg <= pco_map_e'(`PCO_RST_SWAP);
      track_reg <= 1'b0;
      frac_l_reg <= `PCO_RST_FRAC_L;
      frac_h_reg <= `PCO_RST_FRAC_H;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `PCO_OFS_SETUP: setup_reg <= reg_wdata_i[6:0];
        `PCO_OFS_SWAP: swap_reg <= pco_map_e'(reg_wdata_i[1:0]);
        `PCO_OFS_TRACK: track_reg <= reg_wdata_i[0];
        `PCO_OFS_FRAC_L: frac_l_reg <= reg_wdata_i;
        `PCO_OFS_FRAC_H: frac_h_reg <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // divider, host write beats stream rewrite
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      odiv_reg <= `PCO_RST_ODIV;
    end
    else if (soft_reset_i)
    begin
      odiv_reg <= `PCO_RST_ODIV;
    end
    else if (host_wr_odiv)
    begin
      odiv_reg <= reg_wdata_i[4:0];
    end
    else if (core_div_wr_i && !track_reg)
    begin
      odiv_reg <= core_div_i;
    end
  end

  // operating fine-tune word loaded at stream sync
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync_d_reg <= 1'b0;
      frac_op_reg <= {`PCO_RST_FRAC_H, `PCO_RST_FRAC_L};
    end
    else
    begin
      sync_d_reg <= stream_sync_i;
      if (stream_sync_i && !sync_d_reg)
      begin
        frac_op_reg <= {frac_h_reg, frac_l_reg};
      end
    end
  end

  always_comb
  begin
    pll_o.fine_tune = frac_op_reg;
    pll_o.out_div = odiv_reg;
    pll_o.tracking = track_reg;
    pll_o.ratio = track_reg ? PCO_FS256 : fs_ratio_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      run_reg <= 1'b0;
      op_mode_reg <= '0;
    end
    else if (soft_reset_i)
    begin
      run_reg <= 1'b0;
      op_mode_reg <= '0;
    end
    else if (run_set && !run_reg)
    begin
      run_reg <= 1'b1;
      op_mode_reg <= operation_select_i;
    end
  end
  assign running_o = run_reg;
  assign op_mode_o = op_mode_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tally_reg <= '0;
      rate_reg <= '0;
    end
    else if (soft_reset_i)
    begin
      tally_reg <= '0;
      rate_reg <= '0;
    end
    else if (frame_done_i && run_reg)
    begin
      tally_reg <= tally_reg + 24'h000001;
      rate_reg <= 8'((10'(avg_rate_kbps_i) + 10'h001) >> 1);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_reg <= '0;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `PCO_OFS_SETUP: rdata_reg <= {1'b0, setup_reg};
        `PCO_OFS_SWAP: rdata_reg <= {6'h00, swap_reg};
        `PCO_OFS_ODIV: rdata_reg <= {3'h0, odiv_reg};
        `PCO_OFS_TRACK: rdata_reg <= {7'h00, track_reg};
        `PCO_OFS_FRAC_L: rdata_reg <= frac_l_reg;
        `PCO_OFS_FRAC_H: rdata_reg <= frac_h_reg;
        `PCO_OFS_TALLY_L: rdata_reg <= tally_reg[7:0];
        `PCO_OFS_TALLY_M: rdata_reg <= tally_reg[15:8];
        `PCO_OFS_TALLY_H: rdata_reg <= tally_reg[23:16];
        `PCO_OFS_RATE: rdata_reg <= rate_reg;
        `PCO_OFS_FWREV: rdata_reg <= FW_REVISION;
        `PCO_OFS_RUN: rdata_reg <= {7'h00, run_reg};
        default: rdata_reg <= '0;
      endcase
    end
  end
  assign reg_rdata_o = rdata_reg;

  // Oversampling clock pin synchroniser and rise detect
  logic ovs_s1_reg;
  logic ovs_s2_reg;
  logic ovs_s3_reg;
  logic ovs_rise;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ovs_s1_reg <= 1'b0;
      ovs_s2_reg <= 1'b0;
      ovs_s3_reg <= 1'b0;
    end
    else
    begin
      ovs_s1_reg <= ovs_clk_i;
      ovs_s2_reg <= ovs_s1_reg;
      ovs_s3_reg <= ovs_s2_reg;
    end
  end
  assign ovs_rise = ovs_s2_reg && !ovs_s3_reg;

  // bit clock toggles every (1+divider) oversampling periods
  logic [7:0] bdiv_reg;
  logic sbclk_reg;
  logic half_tick;
  logic launch;
  assign half_tick = run_reg && ovs_rise && (bdiv_reg == bit_clock_divider_i);
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bdiv_reg <= '0;
      sbclk_reg <= 1'b0;
    end
    else if (!run_reg)
    begin
      bdiv_reg <= '0;
      sbclk_reg <= 1'b0;
    end
    else if (ovs_rise)
    begin
      bdiv_reg <= half_tick ? 8'h00 : bdiv_reg + 8'h01;
      if (half_tick)
      begin
        sbclk_reg <= !sbclk_reg;
      end
    end
  end
  // launch edge: falling when select is 1, else rising
  assign launch = half_tick &&
    (sbclk_reg == setup_reg.bitclock_edge_select);
  assign serial_bit_clock_o = sbclk_reg;

  // Sample buffer, drained once per word-select period
  pco_frame_s head;
  logic head_valid;
  logic pop;
  pco_fifo #(.WIDTH($bits(pco_frame_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(pcm_valid_i),
    .in_ready_o(pcm_ready_o),
    .in_data_i(pcm_data_i),
    .out_valid_o(head_valid),
    .out_ready_i(pop),
    .out_data_o(head)
  );

  logic [5:0] dcnt_reg;
  logic [5:0] last_bit;
  logic [5:0] ws_idx;
  logic wide;
  logic ws_right;
  assign wide = (setup_reg.sample_width_select != PCO_W16);
  assign last_bit = wide ? `PCO_SLOT32 : `PCO_SLOT16;
  assign pop = launch && (dcnt_reg == last_bit) && head_valid;
  // I2S framing moves word select one bit ahead of the data
  assign ws_idx = setup_reg.serial_style_select ? dcnt_reg
    : dcnt_reg + 6'h01;
  assign ws_right = wide ? ws_idx[5] : ws_idx[4];

  pco_frame_s cur_reg;
  pco_frame_s mapped;
  always_comb
  begin
    mapped = head;
    case (swap_reg)
      PCO_MAP_THRU: mapped = head;
      PCO_MAP_LEFT: mapped = '{left: head.left, right: head.left};
      PCO_MAP_RIGHT: mapped = '{left: head.right, right: head.right};
      PCO_MAP_SWAP: mapped = '{left: head.right, right: head.left};
      default: mapped = head;
    endcase
  end

  function automatic logic pick_bit(input logic [23:0] smp,
    input pco_width_e wsel, input logic [4:0] k, input logic pad_left,
    input logic lsb_first);
    int w;
    int s;
    int pos;
    int j;
    w = 16;
    s = 16;
    case (wsel)
      PCO_W16: w = 16;
      PCO_W18: w = 18;
      PCO_W20: w = 20;
      default: w = 24;
    endcase
    if (wsel != PCO_W16)
    begin
      s = 32;
    end
    pos = pad_left ? int'(k) - (s - w) : int'(k);
    if (pos < 0 || pos >= w)
    begin
      return 1'b0;
    end
    j = lsb_first ? pos : w - 1 - pos;
    return smp[24 - w + j];
  endfunction

  logic sdata_reg;
  logic ws_reg;
  logic data_right;
  logic [4:0] slot_k;
  assign data_right = wide ? dcnt_reg[5] : dcnt_reg[4];
  assign slot_k = wide ? dcnt_reg[4:0] : {1'b0, dcnt_reg[3:0]};
  // word select level, bit count per period
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      dcnt_reg <= '0;
      cur_reg <= '0;
      sdata_reg <= 1'b0;
      ws_reg <= 1'b0;
    end
    else if (!run_reg)
    begin
      dcnt_reg <= '0;
      cur_reg <= '0;
      sdata_reg <= 1'b0;
      ws_reg <= !setup_reg.frame_polarity_flip;
    end
    else if (launch)
    begin
      dcnt_reg <= (dcnt_reg == last_bit) ? 6'h00 : dcnt_reg + 6'h01;
      if (dcnt_reg == last_bit)
      begin
        cur_reg <= head_valid ? mapped : '0;
      end
      ws_reg <= ws_right ^ !setup_reg.frame_polarity_flip;
      sdata_reg <= pick_bit(data_right ? cur_reg.right : cur_reg.left,
        setup_reg.sample_width_select, slot_k, setup_reg.pad_side_select,
        setup_reg.lsb_first_select);
    end
  end
  assign serial_data_o = sdata_reg;
  assign word_select_clock_o = ws_reg;

  sequence seq_run_write;
    run_set && !run_reg && !soft_reset_i;
  endsequence
  sequence seq_launch_wrap;
    launch && (dcnt_reg == last_bit);
  endsequence

  AST_SOFT_SETUP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    soft_reset_i |=> (setup_reg.serial_style_select == 1'b0)
      && (setup_reg == `PCO_RST_SETUP))
    else $error("setup not restored by soft reset");
  AST_RUN_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
    seq_run_write |=> running_o && (op_mode_o == $past(operation_select_i)))
    else $error("run write did not start decoding");
  AST_MODE_HELD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    running_o && !soft_reset_i |=> $stable(op_mode_o))
    else $error("mode changed while running");
  AST_TALLY_INC: assert property (@(posedge clk_i) disable iff (!resetn_i)
    frame_done_i && running_o && !soft_reset_i
      |=> tally_reg == $past(tally_reg) + 24'h000001)
    else $error("frame tally did not advance");
  AST_RATE_HALF: assert property (@(posedge clk_i) disable iff (!resetn_i)
    frame_done_i && running_o && !soft_reset_i
      |=> rate_reg == 8'((10'($past(avg_rate_kbps_i)) + 10'h001) >> 1))
    else $error("rate not halved");
  AST_TRACK_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    track_reg && !host_wr_odiv && !soft_reset_i |=> $stable(odiv_reg))
    else $error("divider moved in tracking mode");
  AST_FRAC_LOAD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    stream_sync_i && !sync_d_reg
      |=> pll_o.fine_tune == {$past(frac_h_reg), $past(frac_l_reg)})
    else $error("fine-tune word not loaded at sync");
  AST_FRAME_WRAP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    seq_launch_wrap |=> (dcnt_reg == 6'h00) ##0 (dcnt_reg <= last_bit))
    else $error("bit count per period wrong");
  AST_BCLK_DIV: assert property (@(posedge clk_i) disable iff (!resetn_i)
    running_o && $changed(sbclk_reg) |-> $past(ovs_rise)
      && ($past(bdiv_reg) == $past(bit_clock_divider_i)))
    else $error("bit clock toggled off its divider");
  AST_WS_LEVEL: assert property (@(posedge clk_i) disable iff (!resetn_i)
    launch && running_o && !soft_reset_i
      |=> ws_reg == ($past(ws_right) ^ !$past(setup_reg.frame_polarity_flip)))
    else $error("word select polarity wrong");
  AST_DONTCARE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_rd_i && (reg_addr_i == `PCO_OFS_SETUP) |=> reg_rdata_o[7] == 1'b0)
    else $error("don't-care bit read as one");
endmodule // pco_top
`default_nettype wire

// ===== dv/pco_dac_model.sv
// Purpose: Receiving DAC on the serial PCM output of the block
// Assumes: The block's serial pins change on clk_i rising edges only
// Notes: Sampling edge, word length and polarity follow setup_i
`timescale 1ns/1ps
`default_nettype none
module pco_dac_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Setup byte as written to the block
  input wire logic [7:0] setup_i,
  // Serial pins
  input wire logic sbc_i,
  input wire logic ws_i,
  input wire logic sd_i,
  // Received words and framing
  output logic [31:0] left_o,
  output logic [31:0] right_o,
  output logic [6:0] half_len_o,
  output logic [15:0] halves_o
);
  logic sbc_reg;
  logic ws_reg;
  logic [31:0] shift_reg;
  logic [6:0] cnt_reg;
  logic [31:0] word;
  logic take;
  assign take = (sbc_i != sbc_reg) && (sbc_i == setup_i[2]);
  // word assembled first-in high; in I2S the last bit
  // comes with the select change, in other framings the next first bit
  assign word = setup_i[3] ?
    ((setup_i[1:0] == 2'h0) ? {16'h0000, shift_reg[15:0]} : shift_reg) :
    ((setup_i[1:0] == 2'h0) ? {16'h0000, shift_reg[14:0], sd_i}
    : {shift_reg[30:0], sd_i});
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sbc_reg <= 1'h0;
      ws_reg <= 1'h1;
      shift_reg <= 32'h0;
      cnt_reg <= 7'h0;
      left_o <= 32'h0;
      right_o <= 32'h0;
      half_len_o <= 7'h0;
      halves_o <= 16'h0;
    end
    else
    begin
      sbc_reg <= sbc_i;
      if (take)
      begin
        shift_reg <= {shift_reg[30:0], sd_i};
        ws_reg <= ws_i;
        if (ws_i != ws_reg)
        begin
          half_len_o <= cnt_reg + 7'h1;
          cnt_reg <= 7'h0;
          halves_o <= halves_o + 16'h1;
          if (ws_reg != setup_i[4])
            left_o <= word;
          else
            right_o <= word;
        end
        else
          cnt_reg <= cnt_reg + 7'h1;
      end
    end
  end
endmodule // pco_dac_model
`default_nettype wire

// ===== dv/tb.sv
// Purpose: Self-checking bench of the PCM output and clock setup block
// Assumes: Oversampling clock runs at a quarter of clk_i
// Notes: Serial words are judged through the receiving DAC model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pco_pkg::*;
  logic clk_i;
  logic resetn_i;
  logic srst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [4:0] cdiv;
  logic cdiv_wr;
  logic sync;
  logic fdone;
  logic [8:0] avg;
  logic [2:0] opsel;
  logic [2:0] op_mode;
  logic running;
  pco_frame_s pcm;
  logic pcm_valid;
  logic pcm_ready;
  pco_ratio_e fs_ratio;
  pco_pll_s pll;
  logic [1:0] ovs_cnt;
  logic [7:0] bdiv;
  logic sbc;
  logic ws;
  logic sd;
  logic [7:0] setup;
  logic [31:0] left;
  logic [31:0] right;
  logic [6:0] half_len;
  logic [15:0] halves;
  logic [23:0] el;
  logic [23:0] er;
  int errors;
  int total_checks;
  int i;
  int k;
  int n;
  localparam logic [7:0] FW = 8'h3c; // Arbitrary value
  localparam logic [23:0] SL = 24'h9a5c31;
  localparam logic [23:0] SR = 24'h36e7c8;
  localparam logic [7:0] RA [12] = '{8'h55, 8'h56, 8'h61, 8'h63, 8'h64,
    8'h65, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h71, 8'h60};
  localparam logic [7:0] RR [12] = '{8'h21, 8'h00, 8'h07, 8'h00, 8'h46,
    8'h5b, 8'h00, 8'h00, 8'h00, 8'h00, FW, 8'h00};
  localparam logic [7:0] RM [12] = '{8'h7f, 8'h03, 8'h1f, 8'h01, 8'hff,
    8'hff, 8'h00, 8'h00, 8'h00, 8'h00, FW, 8'h00};
  localparam logic [7:0] CS [10] = '{8'h00, 8'h07, 8'h23, 8'h11, 8'h32,
    8'h40, 8'h09, 8'h00, 8'h00, 8'h00};
  localparam logic [1:0] CM [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h0, 2'h1, 2'h2, 2'h3};
  pco_top #(.FW_REVISION(FW), .FIFO_DEPTH(16)) uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .soft_reset_i(srst),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .core_div_i(cdiv), .core_div_wr_i(cdiv_wr),
    .stream_sync_i(sync), .frame_done_i(fdone), .avg_rate_kbps_i(avg),
    .operation_select_i(opsel), .op_mode_o(op_mode), .running_o(running),
    .pcm_data_i(pcm), .pcm_valid_i(pcm_valid), .pcm_ready_o(pcm_ready),
    .fs_ratio_i(fs_ratio), .pll_o(pll), .ovs_clk_i(ovs_cnt[1]),
    .bit_clock_divider_i(bdiv), .serial_bit_clock_o(sbc),
    .word_select_clock_o(ws), .serial_data_o(sd));
  pco_dac_model dac (.clk_i(clk_i), .resetn_i(resetn_i), .setup_i(setup),
    .sbc_i(sbc), .ws_i(ws), .sd_i(sd), .left_o(left), .right_o(right),
    .half_len_o(half_len), .halves_o(halves));
  initial
  begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    ovs_cnt <= ovs_cnt + 2'h1;
  task automatic end_of_test();
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_i);
    wr <= 1'h0;
    @(negedge clk_i);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_i);
    rd <= 1'h0;
    @(negedge clk_i);
    chk($sformatf("register %h", a), e, rdata);
  endtask
  task automatic soft_rst();
    @(posedge clk_i);
    srst <= 1'h1;
    @(posedge clk_i);
    srst <= 1'h0;
    @(negedge clk_i);
  endtask
  task automatic core_div(input logic [4:0] v);
    @(posedge clk_i);
    cdiv <= v;
    cdiv_wr <= 1'h1;
    @(posedge clk_i);
    cdiv_wr <= 1'h0;
    @(negedge clk_i);
  endtask
  task automatic wait_halves(input int h);
    int j;
    logic [15:0] h0;
    h0 = halves;
    for (j = 0; j < 600 * h && 16'(halves - h0) < h; j++)
      @(posedge clk_i);
    @(negedge clk_i);
    if (16'(halves - h0) < h)
      tmo();
  endtask
  task automatic chk_gap(input int e);
    int j;
    int c;
    logic l;
    repeat (24) @(negedge clk_i);
    l = sbc;
    for (j = 0; j < 99 && sbc === l; j++)
      @(negedge clk_i);
    l = sbc;
    c = 0;
    for (j = 0; j < 99 && sbc === l; j++)
    begin
      @(negedge clk_i);
      c++;
    end
    if (j == 99)
      tmo();
    chk("bit clock half period", e, c);
  endtask
  task automatic tmo();
    errors++;
    end_of_test();
  endtask
  function automatic logic [31:0] exp_word(input logic [23:0] s,
    input logic [7:0] c);
    logic [31:0] d;
    logic [15:0] r;
    int w;
    w = 16 + 2 * int'(c[1:0]) + ((c[1:0] == 2'h3) ? 2 : 0);
    d = {8'h00, s} >> (24 - w);
    for (int j = 0; j < 16; j++)
      r[j] = d[15 - j];
    if (c[1:0] == 2'h0 && c[6])
      d = {16'h0000, r};
    else if (c[1:0] != 2'h0 && !c[5])
      d = d << (32 - w);
    return d;
  endfunction
  initial
  begin
    resetn_i = 1'h0;
    srst = 1'h0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
    cdiv = 5'h00;
    cdiv_wr = 1'h0;
    sync = 1'h0;
    fdone = 1'h0;
    avg = 9'h000;
    opsel = 3'h3;
    pcm = {SL, SR};
    pcm_valid = 1'h0;
    fs_ratio = PCO_FS256;
    ovs_cnt = 2'h0;
    bdiv = 8'h01;
    setup = 8'h21;
    errors = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'h1;
    for (i = 0; i < 12; i++)
      rd_reg(RA[i], RR[i]);
    rd_reg(8'h72, 8'h00);
    for (i = 0; i < 12; i++)
    begin
      wr_reg(RA[i], 8'hff);
      rd_reg(RA[i], RM[i]);
    end
    soft_rst();
    for (i = 0; i < 12; i++)
      rd_reg(RA[i], RR[i]);
    chk("fine_tune", 16'h5b46, pll.fine_tune);
    wr_reg(8'h64, 8'h12);
    wr_reg(8'h65, 8'h34);
    chk("fine_tune", 16'h5b46, pll.fine_tune);
    @(posedge clk_i);
    sync <= 1'h1;
    repeat (3) @(negedge clk_i);
    chk("fine_tune", 16'h3412, pll.fine_tune);
    core_div(5'h0a);
    rd_reg(8'h61, 8'h0a);
    chk("out_div", 5'h0a, pll.out_div);
    @(posedge clk_i);
    addr <= 8'h61;
    wdata <= 8'h03;
    wr <= 1'h1;
    cdiv <= 5'h11;
    cdiv_wr <= 1'h1;
    @(posedge clk_i);
    wr <= 1'h0;
    cdiv_wr <= 1'h0;
    rd_reg(8'h61, 8'h03);
    for (n = 1; n >= 0; n--)
    begin
      wr_reg(8'h63, 8'(n));
      core_div(5'h15);
      rd_reg(8'h61, (n == 1) ? 8'h03 : 8'h15);
      chk("tracking", n, pll.tracking);
      for (k = 0; k < 3; k++)
      begin
        @(posedge clk_i);
        fs_ratio <= pco_ratio_e'(k);
        @(negedge clk_i);
        chk("ratio", (n == 1) ? 0 : k, pll.ratio);
      end
    end
    @(posedge clk_i);
    pcm_valid <= 1'h1;
    n = 0;
    for (k = 0; k < 40; k++)
    begin
      @(negedge clk_i);
      if (pcm_ready === 1'h1)
        n++;
    end
    chk("samples accepted", 16, n);
    chk("pcm_ready_o", 1'h0, pcm_ready);
    setup = 8'h00;
    wr_reg(8'h55, 8'h00);
    wr_reg(8'h72, 8'h01);
    chk("running_o", 1'h1, running);
    chk("op_mode_o", 3'h3, op_mode);
    @(posedge clk_i);
    opsel <= 3'h4;
    wr_reg(8'h72, 8'h00);
    rd_reg(8'h72, 8'h01);
    chk("op_mode_o", 3'h3, op_mode);
    chk_gap(8);
    @(posedge clk_i);
    bdiv <= 8'h00;
    chk_gap(4);
    for (i = 0; i < 10; i++)
    begin
      setup = CS[i];
      wr_reg(8'h55, CS[i]);
      wr_reg(8'h56, {6'h00, CM[i]});
      wait_halves(6);
      el = CM[i][1] ? SR : SL;
      er = CM[i][0] ? SL : SR;
      chk("half_len", (CS[i][1:0] == 2'h0) ? 16 : 32, half_len);
      chk("left", exp_word(el, CS[i]), left);
      chk("right", exp_word(er, CS[i]), right);
    end
    @(posedge clk_i);
    pcm_valid <= 1'h0;
    wait_halves(40);
    chk("left drained", 32'h0, left);
    chk("right drained", 32'h0, right);
    @(posedge clk_i);
    avg <= 9'h12d;
    repeat (257)
    begin
      @(posedge clk_i);
      fdone <= 1'h1;
      @(posedge clk_i);
      fdone <= 1'h0;
    end
    rd_reg(8'h67, 8'h01);
    rd_reg(8'h68, 8'h01);
    rd_reg(8'h69, 8'h00);
    rd_reg(8'h6a, 8'h97);
    soft_rst();
    rd_reg(8'h67, 8'h00);
    rd_reg(8'h72, 8'h00);
    chk("running_o", 1'h0, running);
    chk("fine_tune", 16'h3412, pll.fine_tune);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
